// ===== ipve_pkg.sv
/*
 Shared constants for the interrupt priority vector encoder: widths,
 source mirror bit positions, priority order of the sources and their
 pre-shifted vector codes. Assumes a single clock domain.
*/
package ipve_pkg;

	localparam int IPVE_VEC_W   = 6;
	localparam int IPVE_REG_W   = 8;
	localparam int IPVE_MIR_W   = 16;
	localparam int IPVE_NUM_SRC = 18;
	localparam int IPVE_NUM_EDG = 9;

	localparam logic [IPVE_VEC_W-1:0] IPVE_NO_IRQ = 6'h00;

	// priority order, index 0 is the most urgent real source
	localparam int IPVE_PRI_LOW_VOLT  = 0;
	localparam int IPVE_PRI_REG_HOT   = 1;
	localparam int IPVE_PRI_LOW_BAT   = 2;
	localparam int IPVE_PRI_TCH0      = 3;
	localparam int IPVE_PRI_TCH1      = 4;
	localparam int IPVE_PRI_TCH2      = 5;
	localparam int IPVE_PRI_TCH3      = 6;
	localparam int IPVE_PRI_TWRAP     = 7;
	localparam int IPVE_PRI_SER_ERR   = 8;
	localparam int IPVE_PRI_SER_TX    = 9;
	localparam int IPVE_PRI_SER_RX    = 10;
	localparam int IPVE_PRI_ADC       = 11;
	localparam int IPVE_PRI_BUS_HOT   = 12;
	localparam int IPVE_PRI_HS_HOT    = 13;
	localparam int IPVE_PRI_LS_HOT    = 14;
	localparam int IPVE_PRI_HALL_HOT  = 15;
	localparam int IPVE_PRI_HIGH_VOLT = 16;
	localparam int IPVE_PRI_OVERVOLT  = 17;

	localparam logic [IPVE_VEC_W-1:0] IPVE_CODE [IPVE_NUM_SRC] = '{
		6'h02, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12,
		6'h14, 6'h16, 6'h18, 6'h1A, 6'h1C, 6'h1E, 6'h20, 6'h22, 6'h24
	};

	// edge-triggered flags held in this block
	localparam int IPVE_EDG_LOW_VOLT  = 0;
	localparam int IPVE_EDG_REG_HOT   = 1;
	localparam int IPVE_EDG_LOW_BAT   = 2;
	localparam int IPVE_EDG_HIGH_VOLT = 3;
	localparam int IPVE_EDG_OVERVOLT  = 4;
	localparam int IPVE_EDG_BUS_HOT   = 5;
	localparam int IPVE_EDG_HS_HOT    = 6;
	localparam int IPVE_EDG_LS_HOT    = 7;
	localparam int IPVE_EDG_HALL_HOT  = 8;
	localparam logic [IPVE_NUM_EDG-1:0] IPVE_VOLT_MASK = 9'h01F;

	// source mirror bit positions
	localparam int IPVE_MIR_VOLT     = 0;
	localparam int IPVE_MIR_TCH0     = 1;
	localparam int IPVE_MIR_TCH1     = 2;
	localparam int IPVE_MIR_TCH2     = 3;
	localparam int IPVE_MIR_TCH3     = 4;
	localparam int IPVE_MIR_TWRAP    = 5;
	localparam int IPVE_MIR_SER_ERR  = 6;
	localparam int IPVE_MIR_SER_TX   = 7;
	localparam int IPVE_MIR_SER_RX   = 8;
	localparam int IPVE_MIR_ADC      = 9;
	localparam int IPVE_MIR_BUS_HOT  = 10;
	localparam int IPVE_MIR_HS_HOT   = 11;
	localparam int IPVE_MIR_LS_HOT   = 12;
	localparam int IPVE_MIR_HALL_HOT = 13;

endpackage

// ===== ipve_onset_flags.sv
/*
 Bank of sticky flags that set on the rising edge of a condition and
 clear on an acknowledge strobe. Conditions and strobes come from logic
 on the same clock.
*/
`timescale 1ns/1ns
module ipve_onset_flags
	import ipve_pkg::*;
#(
	parameter int N = IPVE_NUM_EDG
) (
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	input  wire logic [N-1:0] cond_i,
	input  wire logic [N-1:0] ack_i,
	output logic      [N-1:0] flag_o
);

	typedef struct packed {
		logic [N-1:0] prev;
		logic [N-1:0] flag;
	} ipve_onset_s;

	ipve_onset_s st;
	ipve_onset_s next_st;

	always_comb begin
		next_st = st;
		next_st.prev = cond_i;
		// onset only
		// a steady condition never re-arms; set wins over a same-cycle ack
		next_st.flag = (st.flag & ~ack_i) | (cond_i & ~st.prev);
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flag_o = st.flag;

	AST_NO_RETRIGGER: assert property (@(posedge clk_i) disable iff (srst_i)
		(!flag_o[0] && cond_i[0] && st.prev[0]) |=> !flag_o[0])
		else $error("flag re-raised while condition held");

endmodule

// ===== ipve_encoder.sv
/*
 Interrupt priority vector encoder. Gathers pending flags of the analog
 sources, keeps the edge-triggered ones, and registers the source mirror,
 the pre-shifted vector and the host interrupt line every clock.
 Assumes all inputs come from logic on clk_i; status register reads of
 the other modules arrive as one-cycle read strobes.
*/
`timescale 1ns/1ns
module ipve_encoder
	import ipve_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  normal_mode_i,
	input  wire logic                  stop_mode_i,
	input  wire logic                  wake_event_i,
	input  wire logic                  wake_ack_i,
	input  wire logic                  low_volt_cond_i,
	input  wire logic                  regulator_hot_cond_i,
	input  wire logic                  low_battery_cond_i,
	input  wire logic                  high_volt_cond_i,
	input  wire logic                  regulator_overvolt_cond_i,
	input  wire logic                  bus_driver_hot_cond_i,
	input  wire logic                  high_side_hot_cond_i,
	input  wire logic                  low_side_hot_cond_i,
	input  wire logic                  hall_supply_hot_cond_i,
	input  wire logic                  voltage_status_reg_rd_i,
	input  wire logic                  bus_transceiver_reg_rd_i,
	input  wire logic                  high_side_status_reg_rd_i,
	input  wire logic                  low_side_status_reg_rd_i,
	input  wire logic                  hall_supply_reg_rd_i,
	input  wire logic [3:0]            timer_chan_flags_i,
	input  wire logic                  timer_wrap_flag_i,
	input  wire logic                  serial_err_flag_i,
	input  wire logic                  serial_tx_flag_i,
	input  wire logic                  serial_rx_flag_i,
	input  wire logic                  adc_sequence_done_flag_i,
	output logic      [IPVE_REG_W-1:0] interrupt_vector_o,
	output logic      [IPVE_MIR_W-1:0] source_mirror_o,
	output logic                       host_irq_out_o
);

	typedef struct packed {
		logic [IPVE_REG_W-1:0] vec;
		logic [IPVE_MIR_W-1:0] mirror;
		logic                  irq;
		logic                  wake_pend;
	} ipve_state_s;

	ipve_state_s st;
	ipve_state_s next_st;

	logic [IPVE_NUM_EDG-1:0] edge_cond;
	logic [IPVE_NUM_EDG-1:0] edge_ack;
	logic [IPVE_NUM_EDG-1:0] edge_flag;
	logic [IPVE_NUM_SRC-1:0] pend;
	logic                    voltage_group_flag;

	function automatic logic [IPVE_VEC_W-1:0] ipve_encode(input logic [IPVE_NUM_SRC-1:0] p);
		logic [IPVE_VEC_W-1:0] code;
		code = IPVE_NO_IRQ;
		// scan from lowest priority so the most urgent pending one wins
		for (int i = IPVE_NUM_SRC - 1; i >= 0; i--) begin
			if (p[i]) begin
				code = IPVE_CODE[i];
			end
		end
		return code;
	endfunction

	always_comb begin
		edge_cond = '0;
		edge_cond[IPVE_EDG_LOW_VOLT]  = low_volt_cond_i;
		edge_cond[IPVE_EDG_REG_HOT]   = regulator_hot_cond_i;
		edge_cond[IPVE_EDG_LOW_BAT]   = low_battery_cond_i;
		edge_cond[IPVE_EDG_HIGH_VOLT] = high_volt_cond_i;
		edge_cond[IPVE_EDG_OVERVOLT]  = regulator_overvolt_cond_i;
		edge_cond[IPVE_EDG_BUS_HOT]   = bus_driver_hot_cond_i;
		edge_cond[IPVE_EDG_HS_HOT]    = high_side_hot_cond_i;
		edge_cond[IPVE_EDG_LS_HOT]    = low_side_hot_cond_i;
		edge_cond[IPVE_EDG_HALL_HOT]  = hall_supply_hot_cond_i;
	end

	always_comb begin
		edge_ack = '0;
		edge_ack = edge_ack | ({IPVE_NUM_EDG{voltage_status_reg_rd_i}} & IPVE_VOLT_MASK);
		edge_ack[IPVE_EDG_BUS_HOT] = bus_transceiver_reg_rd_i;
		edge_ack[IPVE_EDG_HS_HOT] = high_side_status_reg_rd_i;
		edge_ack[IPVE_EDG_LS_HOT] = low_side_status_reg_rd_i;
		edge_ack[IPVE_EDG_HALL_HOT] = hall_supply_reg_rd_i;
	end

	ipve_onset_flags #(
		.N (IPVE_NUM_EDG)
	) u_onset (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.cond_i (edge_cond),
		.ack_i  (edge_ack),
		.flag_o (edge_flag)
	);

	assign voltage_group_flag = |(edge_flag & IPVE_VOLT_MASK);

	always_comb begin
		pend = '0;
		pend[IPVE_PRI_LOW_VOLT]  = edge_flag[IPVE_EDG_LOW_VOLT];
		pend[IPVE_PRI_REG_HOT]   = edge_flag[IPVE_EDG_REG_HOT];
		pend[IPVE_PRI_LOW_BAT]   = edge_flag[IPVE_EDG_LOW_BAT];
		pend[IPVE_PRI_TCH0]      = timer_chan_flags_i[0];
		pend[IPVE_PRI_TCH1]      = timer_chan_flags_i[1];
		pend[IPVE_PRI_TCH2]      = timer_chan_flags_i[2];
		pend[IPVE_PRI_TCH3]      = timer_chan_flags_i[3];
		pend[IPVE_PRI_TWRAP]     = timer_wrap_flag_i;
		pend[IPVE_PRI_SER_ERR]   = serial_err_flag_i;
		pend[IPVE_PRI_SER_TX]    = serial_tx_flag_i;
		pend[IPVE_PRI_SER_RX]    = serial_rx_flag_i;
		pend[IPVE_PRI_ADC]       = adc_sequence_done_flag_i;
		pend[IPVE_PRI_BUS_HOT]   = edge_flag[IPVE_EDG_BUS_HOT];
		pend[IPVE_PRI_HS_HOT]    = edge_flag[IPVE_EDG_HS_HOT];
		pend[IPVE_PRI_LS_HOT]    = edge_flag[IPVE_EDG_LS_HOT];
		pend[IPVE_PRI_HALL_HOT]  = edge_flag[IPVE_EDG_HALL_HOT];
		pend[IPVE_PRI_HIGH_VOLT] = edge_flag[IPVE_EDG_HIGH_VOLT];
		pend[IPVE_PRI_OVERVOLT]  = edge_flag[IPVE_EDG_OVERVOLT];
	end

	always_comb begin
		next_st = st;
		// stop wake latch
		// set wins over a same-cycle ack so a wake is never lost
		next_st.wake_pend = (st.wake_pend & ~wake_ack_i) | (stop_mode_i & wake_event_i);
		// zero when idle or after wake
		next_st.vec = '0;
		next_st.vec[IPVE_VEC_W-1:0] = st.wake_pend ? IPVE_NO_IRQ : ipve_encode(pend);
		next_st.mirror = '0;
		next_st.mirror[IPVE_MIR_VOLT]     = voltage_group_flag;
		next_st.mirror[IPVE_MIR_TCH0]     = timer_chan_flags_i[0];
		next_st.mirror[IPVE_MIR_TCH1]     = timer_chan_flags_i[1];
		next_st.mirror[IPVE_MIR_TCH2]     = timer_chan_flags_i[2];
		next_st.mirror[IPVE_MIR_TCH3]     = timer_chan_flags_i[3];
		next_st.mirror[IPVE_MIR_TWRAP]    = timer_wrap_flag_i;
		next_st.mirror[IPVE_MIR_SER_ERR]  = serial_err_flag_i;
		next_st.mirror[IPVE_MIR_SER_TX]   = serial_tx_flag_i;
		next_st.mirror[IPVE_MIR_SER_RX]   = serial_rx_flag_i;
		next_st.mirror[IPVE_MIR_ADC]      = adc_sequence_done_flag_i;
		next_st.mirror[IPVE_MIR_BUS_HOT]  = edge_flag[IPVE_EDG_BUS_HOT];
		next_st.mirror[IPVE_MIR_HS_HOT]   = edge_flag[IPVE_EDG_HS_HOT];
		next_st.mirror[IPVE_MIR_LS_HOT]   = edge_flag[IPVE_EDG_LS_HOT];
		next_st.mirror[IPVE_MIR_HALL_HOT] = edge_flag[IPVE_EDG_HALL_HOT];
		// line follows pending in normal mode
		// wake drives the line regardless of mode
		next_st.irq = (normal_mode_i & (|pend)) | st.wake_pend;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// no read path into the flags; vector is pure view
	assign interrupt_vector_o = st.vec;
	assign source_mirror_o    = st.mirror;
	assign host_irq_out_o     = st.irq;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	AST_VEC_EVEN: assert property (interrupt_vector_o[0] == 1'b0)
		else $error("vector code is odd");
	AST_VEC_IDLE_ZERO: assert property (pend == '0 |=> interrupt_vector_o == '0)
		else $error("vector nonzero with nothing pending");
	AST_VEC_TOP_LOWVOLT: assert property (
		(pend[IPVE_PRI_LOW_VOLT] && !st.wake_pend) |=> interrupt_vector_o == 8'h02)
		else $error("low volt not reported first");
	AST_VEC_TIMER0: assert property (
		(pend[IPVE_PRI_TCH0] && pend[IPVE_PRI_TCH0-1:0] == '0 && !st.wake_pend) |=> interrupt_vector_o == 8'h08)
		else $error("timer channel zero code wrong");
	AST_VEC_LOWEST: assert property (
		(pend == (18'h1 << IPVE_PRI_OVERVOLT) && !st.wake_pend) |=> interrupt_vector_o == 8'h24)
		else $error("overvolt code wrong");
	AST_VEC_PRIORITY: assert property (
		(!st.wake_pend && pend != '0) |=>
		($past(pend) & ~({IPVE_NUM_SRC{1'b1}} << interrupt_vector_o[IPVE_VEC_W-1:1]))
		== (18'h1 << (interrupt_vector_o[IPVE_VEC_W-1:1] - 1)))
		else $error("vector names a source that is not the most urgent pending");
	AST_NO_ACK_HOLD: assert property (
		(edge_flag[IPVE_EDG_HS_HOT] && !high_side_status_reg_rd_i) |=> edge_flag[IPVE_EDG_HS_HOT])
		else $error("flag dropped without its status read");
	AST_VOLT_ACK: assert property (
		(voltage_status_reg_rd_i && !low_volt_cond_i && !high_volt_cond_i)
		|=> !edge_flag[IPVE_EDG_LOW_VOLT] && !edge_flag[IPVE_EDG_HIGH_VOLT])
		else $error("voltage read did not clear flags");
	AST_BUS_ACK: assert property (
		(bus_transceiver_reg_rd_i && !bus_driver_hot_cond_i) |=> !edge_flag[IPVE_EDG_BUS_HOT])
		else $error("bus transceiver read did not clear");
	AST_LS_ACK: assert property (
		(low_side_status_reg_rd_i && !low_side_hot_cond_i) |=> !edge_flag[IPVE_EDG_LS_HOT])
		else $error("low side read did not clear");
	AST_HALL_ACK: assert property (
		(hall_supply_reg_rd_i && !hall_supply_hot_cond_i) |=> !edge_flag[IPVE_EDG_HALL_HOT])
		else $error("hall supply read did not clear");
	AST_HS_ACK: assert property (
		(high_side_status_reg_rd_i && !high_side_hot_cond_i) |=> !edge_flag[IPVE_EDG_HS_HOT])
		else $error("high side read did not clear");
	AST_MIRROR_GROUP: assert property (
		##1 source_mirror_o[IPVE_MIR_VOLT] == $past(voltage_group_flag))
		else $error("voltage group bit wrong");
	AST_IRQ_NORMAL: assert property (
		(normal_mode_i && pend != '0) |=> host_irq_out_o)
		else $error("line low with interrupt pending");
	AST_IRQ_QUIET: assert property (
		(!normal_mode_i && !st.wake_pend) |=> !host_irq_out_o)
		else $error("line raised outside normal mode");
	AST_WAKE: assert property (
		(stop_mode_i && wake_event_i) ##1 !wake_ack_i |=> host_irq_out_o && interrupt_vector_o == '0)
		else $error("wake not signalled with code zero");
	AST_RESET: assert property (@(posedge clk_i) disable iff (1'b0)
		srst_i |=> interrupt_vector_o == '0 && !host_irq_out_o && source_mirror_o == '0)
		else $error("outputs not cleared by reset");
	AST_VEC_REG_HOT: assert property (
		(pend == (18'h1 << IPVE_PRI_REG_HOT) && !st.wake_pend) |=> interrupt_vector_o == 8'h04)
		else $error("regulator hot code wrong");
	AST_VEC_LOW_BAT: assert property (
		(pend == (18'h1 << IPVE_PRI_LOW_BAT) && !st.wake_pend) |=> interrupt_vector_o == 8'h06)
		else $error("low battery code wrong");
	AST_VEC_TWRAP: assert property (
		(pend == (18'h1 << IPVE_PRI_TWRAP) && !st.wake_pend) |=> interrupt_vector_o == 8'h10)
		else $error("timer wrap code wrong");
	AST_VEC_SER_ERR: assert property (
		(pend == (18'h1 << IPVE_PRI_SER_ERR) && !st.wake_pend) |=> interrupt_vector_o == 8'h12)
		else $error("serial error code wrong");
	AST_VEC_SER_RX: assert property (
		(pend == (18'h1 << IPVE_PRI_SER_RX) && !st.wake_pend) |=> interrupt_vector_o == 8'h16)
		else $error("serial receive code wrong");
	AST_VEC_ADC: assert property (
		(pend == (18'h1 << IPVE_PRI_ADC) && !st.wake_pend) |=> interrupt_vector_o == 8'h18)
		else $error("adc done code wrong");
	AST_VEC_BUS_HOT: assert property (
		(pend == (18'h1 << IPVE_PRI_BUS_HOT) && !st.wake_pend) |=> interrupt_vector_o == 8'h1A)
		else $error("bus driver hot code wrong");
	AST_VEC_HS_HOT: assert property (
		(pend == (18'h1 << IPVE_PRI_HS_HOT) && !st.wake_pend) |=> interrupt_vector_o == 8'h1C)
		else $error("high side hot code wrong");
	AST_VEC_HALL_HOT: assert property (
		(pend == (18'h1 << IPVE_PRI_HALL_HOT) && !st.wake_pend) |=> interrupt_vector_o == 8'h20)
		else $error("hall supply hot code wrong");
	AST_VEC_HIGH_VOLT: assert property (
		(pend == (18'h1 << IPVE_PRI_HIGH_VOLT) && !st.wake_pend) |=> interrupt_vector_o == 8'h22)
		else $error("high volt code wrong");
	AST_VEC_WAKE_ZERO: assert property (
		st.wake_pend |=> interrupt_vector_o == '0)
		else $error("vector nonzero while wake pending");
	AST_VOLT_ACK_ALL: assert property (
		(voltage_status_reg_rd_i && (edge_cond & IPVE_VOLT_MASK) == '0)
		|=> (edge_flag & IPVE_VOLT_MASK) == '0)
		else $error("voltage read left a voltage flag set");
	AST_MIRROR_TIMER: assert property (
		##1 source_mirror_o[IPVE_MIR_TCH0] == $past(timer_chan_flags_i[0]))
		else $error("timer channel zero mirror bit stale");

	COV_LOWVOLT_IRQ: cover property (pend[IPVE_PRI_LOW_VOLT] ##1 host_irq_out_o);
	COV_WAKE: cover property (stop_mode_i && wake_event_i ##2 host_irq_out_o);
	COV_TWO_PEND: cover property (pend[IPVE_PRI_TCH0] && pend[IPVE_PRI_OVERVOLT]);
	COV_ACK_VOLT: cover property (edge_flag[IPVE_EDG_OVERVOLT] && voltage_status_reg_rd_i);
	COV_WAKE_ACK: cover property (st.wake_pend && wake_ack_i);

endmodule

// ===== ipve_host_model.sv
/*
 Behavioural host that services the encoder: it reads the vector while the
 interrupt line is high and pulses the status read that acknowledges the
 reported source. Assumes the encoder's clock and reset; sources that are
 cleared in their own modules are left to the bench.
*/
`timescale 1ns/1ns
module ipve_host_model
	import ipve_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	input  wire logic                  auto_i,
	input  wire logic [3:0]            delay_i,
	input  wire logic                  host_irq_out_i,
	input  wire logic [IPVE_REG_W-1:0] interrupt_vector_i,
	output logic                       voltage_rd_o,
	output logic                       bus_rd_o,
	output logic                       high_side_rd_o,
	output logic                       low_side_rd_o,
	output logic                       hall_rd_o,
	output logic                       wake_ack_o
);
	logic [4:0] cnt;
	logic [2:0] pick;
	logic [2:0] tgt;
	logic [5:0] rd_q;

	always_comb begin
		case (interrupt_vector_i[5:0])
			6'h02, 6'h04, 6'h06, 6'h22, 6'h24: tgt = 3'h0;
			6'h1A: tgt = 3'h1;
			6'h1C: tgt = 3'h2;
			6'h1E: tgt = 3'h3;
			6'h20: tgt = 3'h4;
			6'h00: tgt = 3'h5;
			default: tgt = 3'h7;
		endcase
	end

	// holdoff after the pulse, the line falls two cycles late
	always_ff @(posedge clk_i) begin
		rd_q <= 6'h00;
		if (srst_i) begin
			cnt  <= 5'h00;
			pick <= 3'h0;
		end else if (cnt != 5'h00) begin
			cnt <= cnt - 5'h01;
			if (cnt == 5'h07) begin
				rd_q[pick] <= 1'b1;
			end
		end else if (auto_i && host_irq_out_i && tgt != 3'h7) begin
			cnt  <= {1'b0, delay_i} + 5'h07;
			pick <= tgt;
		end
	end

	assign voltage_rd_o   = rd_q[0];
	assign bus_rd_o       = rd_q[1];
	assign high_side_rd_o = rd_q[2];
	assign low_side_rd_o  = rd_q[3];
	assign hall_rd_o      = rd_q[4];
	assign wake_ack_o     = rd_q[5];
endmodule

// ===== tb_irq_priority_vector_encoder.sv
/*
 Self-checking bench for the interrupt priority vector encoder with a host
 model acknowledging sources. Assumes one 100 MHz clock and the package's
 source order; src bit i is the source of priority index i.
*/
`timescale 1ns/1ns
module tb_irq_priority_vector_encoder;
	import ipve_pkg::*;
	logic        clk, srst, normal_mode, stop_mode, wake_event, auto;
	logic [3:0]  delay;
	logic [17:0] src;
	logic [7:0]  vec;
	logic [15:0] mir;
	logic        irq, vsr_rd, bus_rd, hs_rd, ls_rd, hall_rd, wake_ack;
	int          num_errors, n_tests, vsr_cnt;

	ipve_encoder i_ipve_encoder (.clk_i(clk), .srst_i(srst), .normal_mode_i(normal_mode), .stop_mode_i(stop_mode),
		.wake_event_i(wake_event), .wake_ack_i(wake_ack), .low_volt_cond_i(src[0]), .regulator_hot_cond_i(src[1]),
		.low_battery_cond_i(src[2]), .high_volt_cond_i(src[16]), .regulator_overvolt_cond_i(src[17]),
		.bus_driver_hot_cond_i(src[12]), .high_side_hot_cond_i(src[13]), .low_side_hot_cond_i(src[14]),
		.hall_supply_hot_cond_i(src[15]), .voltage_status_reg_rd_i(vsr_rd), .bus_transceiver_reg_rd_i(bus_rd),
		.high_side_status_reg_rd_i(hs_rd), .low_side_status_reg_rd_i(ls_rd), .hall_supply_reg_rd_i(hall_rd),
		.timer_chan_flags_i(src[6:3]), .timer_wrap_flag_i(src[7]), .serial_err_flag_i(src[8]),
		.serial_tx_flag_i(src[9]), .serial_rx_flag_i(src[10]), .adc_sequence_done_flag_i(src[11]),
		.interrupt_vector_o(vec), .source_mirror_o(mir), .host_irq_out_o(irq));

	ipve_host_model i_ipve_host_model (.clk_i(clk), .srst_i(srst), .auto_i(auto), .delay_i(delay),
		.host_irq_out_i(irq), .interrupt_vector_i(vec), .voltage_rd_o(vsr_rd), .bus_rd_o(bus_rd),
		.high_side_rd_o(hs_rd), .low_side_rd_o(ls_rd), .hall_rd_o(hall_rd), .wake_ack_o(wake_ack));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (vsr_rd === 1'b1) begin
			vsr_cnt++;
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic cmp_vec(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t vector got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic cmp_mir(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t mirror got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t irq got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic cmp_cnt(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t count got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic wait_irq_low(input int lim);
		int k;
		k = 0;
		while (irq !== 1'b0 && k < lim) begin
			tick(1);
			k++;
		end
		cmp_bit(irq, 1'b0);
	endtask

	// voltage sources share mirror bit 0
	function automatic logic [15:0] mir_of(input int i);
		mir_of = (i < 3 || i > 15) ? 16'h0001 : 16'h0001 << (i - 2);
	endfunction

	task automatic test_reset;
		cmp_vec(vec, 8'h00);
		tick(1);
		cmp_mir(mir, 16'h0000);
		cmp_bit(irq, 1'b0);
	endtask

	task automatic test_each;
		auto = 1'b1;
		for (int i = 0; i < 18; i++) begin
			delay = 4'(i % 4);
			src[i] = 1'b1;
			tick(2);
			cmp_vec(vec, 8'(2 * (i + 1)));
			cmp_mir(mir, mir_of(i));
			cmp_bit(irq, 1'b1);
			if (i < 3 || i > 11) begin
				wait_irq_low(40);
				tick(3);
				cmp_bit(irq, 1'b0);
			end
			src[i] = 1'b0;
			tick(2);
			cmp_vec(vec, 8'h00);
			cmp_mir(mir, 16'h0000);
		end
		auto = 1'b0;
	endtask

	task automatic test_order;
		src = 18'h3FFF8;
		delay = 4'hF;
		tick(2);
		for (int i = 3; i < 12; i++) begin
			cmp_vec(vec, 8'(2 * (i + 1)));
			src[i] = 1'b0;
			tick(2);
		end
		cmp_vec(vec, 8'h1A);
		// conditions gone, only the sticky flags keep the line up
		src = '0;
		tick(2);
		cmp_bit(irq, 1'b1);
		cmp_vec(vec, 8'h1A);
		auto = 1'b1;
		wait_irq_low(200);
		cmp_mir(mir, 16'h0000);
		auto = 1'b0;
		tick(2);
	endtask

	task automatic test_volt_group;
		auto = 1'b1;
		delay = 4'h2;
		vsr_cnt = 0;
		src[0] = 1'b1;
		src[16] = 1'b1;
		tick(2);
		cmp_vec(vec, 8'h02);
		wait_irq_low(40);
		cmp_cnt(16'(vsr_cnt), 16'h0001);
		tick(3);
		cmp_bit(irq, 1'b0);
		src[0] = 1'b0;
		tick(2);
		src[0] = 1'b1;
		tick(2);
		cmp_vec(vec, 8'h02);
		// ack with every condition low, so the read alone clears the flags
		src = '0;
		wait_irq_low(40);
		cmp_cnt(16'(vsr_cnt), 16'h0002);
		src = '0;
		auto = 1'b0;
		tick(2);
	endtask

	task automatic test_modes;
		normal_mode = 1'b0;
		src[3] = 1'b1;
		tick(2);
		cmp_bit(irq, 1'b0);
		cmp_mir(mir, 16'h0002);
		stop_mode = 1'b1;
		wake_event = 1'b1;
		tick(1);
		wake_event = 1'b0;
		tick(2);
		cmp_bit(irq, 1'b1);
		cmp_vec(vec, 8'h00);
		auto = 1'b1;
		wait_irq_low(40);
		auto = 1'b0;
		stop_mode = 1'b0;
		normal_mode = 1'b1;
		tick(2);
		cmp_bit(irq, 1'b1);
		cmp_vec(vec, 8'h08);
		src[3] = 1'b0;
		tick(2);
		cmp_bit(irq, 1'b0);
	endtask

	task automatic test_reset_mid;
		src[12] = 1'b1;
		tick(2);
		cmp_vec(vec, 8'h1A);
		srst = 1'b1;
		src[12] = 1'b0;
		tick(1);
		cmp_vec(vec, 8'h00);
		cmp_mir(mir, 16'h0000);
		cmp_bit(irq, 1'b0);
		srst = 1'b0;
		tick(2);
		cmp_vec(vec, 8'h00);
		cmp_bit(irq, 1'b0);
	endtask

	task automatic complete_run;
		if (num_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// whole sequence needs well under 20 us
	initial begin
		#200000;
		num_errors++;
		complete_run;
	end

	initial begin
		num_errors = 0;
		n_tests = 0;
		vsr_cnt = 0;
		srst = 1'b1;
		normal_mode = 1'b1;
		stop_mode = 1'b0;
		wake_event = 1'b0;
		auto = 1'b0;
		delay = 4'h0;
		src = '0;
		repeat (12) @(posedge clk);
		#1;
		srst = 1'b0;
		test_reset;
		test_each;
		test_order;
		test_volt_group;
		test_modes;
		test_reset_mid;
		complete_run;
	end
endmodule
